// ===== shared/ovfs_consts.vh
`ifndef OVFS_CONSTS_VH
`define OVFS_CONSTS_VH
// Comparator sync depth
`define OVFS_SYNC_DEPTH 3
// Reset values of the fault latches
`define OVFS_UV_LATCH_RST 1'b0
`define OVFS_OV_LATCH_RST 1'b0
// Power-good reset value
`define OVFS_PG_RST 1'b0
// Comparator vector bit positions
`define OVFS_CMP_UV 0
`define OVFS_CMP_OV 1
`define OVFS_CMP_WIN 2
`define OVFS_CMP_HALF 3
`define OVFS_CMP_SS 4
`define OVFS_CMP_W 5
`endif

// ===== hw/ovfs_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser with agreement filter on stages two and three
module ovfs_sync #(
   parameter W = 5
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire [W-1:0] rst_val_i,
   input wire [W-1:0] async_i,
   output reg [W-1:0] level_o
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   integer k;

   // Shift chain; filtered level follows once stages two and three agree
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         s1_reg <= rst_val_i;
         s2_reg <= rst_val_i;
         s3_reg <= rst_val_i;
         level_o <= rst_val_i;
      end
      else if (ce_i)
      begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (k = 0; k < W; k = k + 1)
            if (s2_reg[k] == s3_reg[k])
               level_o[k] <= s2_reg[k];
      end
   end
endmodule

// ===== hw/ovfs_supervisor.v
`timescale 1ns/10ps
`include "ovfs_consts.vh"
module ovfs_supervisor (
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire output_sense_below_uv_i,
   input wire output_sense_above_ov_i,
   input wire output_sense_in_window_i,
   input wire output_sense_above_half_i,
   input wire soft_start_done_i,
   input wire low_side_mask_i,
   input wire pwm_high_side_req_i,
   input wire pwm_low_side_req_i,
   output reg power_good_flag_o,
   output reg high_side_gate_o,
   output reg low_side_gate_o,
   output wire undervoltage_trip_o,
   output wire overvoltage_trip_o,
   output wire sense_bias_en_o
);
   // Low-side ownership states, one-hot
   localparam [2:0] LS_LOOP = 3'h1;
   localparam [2:0] LS_FORCED_ON = 3'h2;
   localparam [2:0] LS_FORCED_OFF = 3'h4;
   // State bit that means protection holds the low side on
   localparam LS_ON_BIT = 1;

   // Raw and filtered comparator levels
   wire [`OVFS_CMP_W-1:0] cmp_raw;
   wire [`OVFS_CMP_W-1:0] cmp_s;
   // Named views of the filtered levels
   wire ss_done;
   wire sense_low;
   wire sense_high;
   wire sense_in_window;
   wire sense_above_half;
   // Fault conditions seen this cycle
   wire uv_now;
   wire ov_now;
   // Loop low-side request after the start-up mask
   wire pwm_ls_masked;
   // Fault latches
   reg uv_latch_reg;
   reg uv_latch_next;
   reg ov_latch_reg;
   reg ov_latch_next;
   // Low-side protection state
   reg [2:0] ls_state_reg;
   reg [2:0] ls_state_next;
   reg ls_on_next;
   // Fault decode for the overrides
   reg fault_any_next;
   reg uv_only_next;
   // Next values of the registered outputs
   reg hs_next;
   reg ls_next;
   reg pg_next;

   // Gate level: UV off, else OV level, else the loop request
   function gate_pick;
      input uv_only;
      input ov_owns;
      input ov_level;
      input pwm_level;
      begin
         if (uv_only)
            gate_pick = 1'b0;
         else if (ov_owns)
            gate_pick = ov_level;
         else
            gate_pick = pwm_level;
      end
   endfunction

   // Comparator and soft-start levels gathered for the synchroniser
   assign cmp_raw = {soft_start_done_i, output_sense_above_half_i,
                     output_sense_in_window_i, output_sense_above_ov_i,
                     output_sense_below_uv_i};

   // Comparator and soft-start status cross into the clock domain
   ovfs_sync #(.W(`OVFS_CMP_W)) ovfs_sync_inst (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .rst_val_i({`OVFS_CMP_W{1'b0}}),
      .async_i(cmp_raw),
      .level_o(cmp_s)
   );

   // Named views of the filtered levels
   assign ss_done = cmp_s[`OVFS_CMP_SS];
   assign sense_low = cmp_s[`OVFS_CMP_UV];
   assign sense_high = cmp_s[`OVFS_CMP_OV];
   assign sense_in_window = cmp_s[`OVFS_CMP_WIN];
   assign sense_above_half = cmp_s[`OVFS_CMP_HALF];

   // Bias source always on; open pin floats high to over-voltage
   assign sense_bias_en_o = 1'b1;

   // Under-voltage only counts once soft-start is over
   assign uv_now = sense_low & ss_done;
   // Over-voltage counts at all times, soft-start included
   assign ov_now = sense_high;

   // Start-up mask hides only the loop's low-side request
   assign pwm_ls_masked = pwm_low_side_req_i & ~low_side_mask_i;

   // Latched faults leave the block as status
   assign undervoltage_trip_o = uv_latch_reg;
   assign overvoltage_trip_o = ov_latch_reg;

   // Fault latches; only reset clears them, and reset wins over a set in the same cycle
   always @*
   begin
      uv_latch_next = uv_latch_reg | uv_now;
      ov_latch_next = ov_latch_reg | ov_now;
   end

   // Low-side ownership: loop until OV, then follow half reference
   always @*
   begin
      ls_state_next = ls_state_reg;
      case (ls_state_reg)
         LS_LOOP:
         begin
            if (ov_now)
               ls_state_next = LS_FORCED_ON;
         end
         LS_FORCED_ON:
         begin
            if (~ov_now & ~sense_above_half)
               ls_state_next = LS_FORCED_OFF;
         end
         LS_FORCED_OFF:
         begin
            if (ov_now | sense_above_half)
               ls_state_next = LS_FORCED_ON;
         end
         // Unknown code: take the safe clamp
         default:
            ls_state_next = LS_FORCED_ON;
      endcase
      ls_on_next = ls_state_next[LS_ON_BIT];
   end

   // Fault decode; with both latched, OV keeps low-side control
   always @*
   begin
      fault_any_next = uv_latch_next | ov_latch_next;
      uv_only_next = uv_latch_next & ~ov_latch_next;
   end

   // High side: any latched fault holds it off
   always @*
   begin
      hs_next = gate_pick(uv_only_next, ov_latch_next, 1'b0,
                          pwm_high_side_req_i);
   end

   // Low side: protection may drive it despite the start-up mask
   always @*
   begin
      ls_next = gate_pick(uv_only_next, ov_latch_next, ls_on_next,
                          pwm_ls_masked);
   end

   // Power good: soft-start over, inside window, no latched fault
   always @*
   begin
      pg_next = ss_done & sense_in_window;
      if (fault_any_next)
         pg_next = 1'b0;
   end

   // Fault latches and low-side protection state
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         uv_latch_reg <= `OVFS_UV_LATCH_RST;
         ov_latch_reg <= `OVFS_OV_LATCH_RST;
         ls_state_reg <= LS_LOOP;
      end
      else if (ce_i)
      begin
         uv_latch_reg <= uv_latch_next;
         ov_latch_reg <= ov_latch_next;
         ls_state_reg <= ls_state_next;
      end
   end

   // Registered gate outputs
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         high_side_gate_o <= 1'b0;
         low_side_gate_o <= 1'b0;
      end
      else if (ce_i)
      begin
         high_side_gate_o <= hs_next;
         low_side_gate_o <= ls_next;
      end
   end

   // Registered power-good flag
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
         power_good_flag_o <= `OVFS_PG_RST;
      else if (ce_i)
         power_good_flag_o <= pg_next;
   end
endmodule

// ===== tb/ovfs_sense.sv
`timescale 1ns/10ps
// Sense node model; an open pin is pulled above OV by the bias
module ovfs_sense(
input wire [2:0] lvl_i,
input wire open_i,
output wire uv_o,
output wire ov_o,
output wire win_o,
output wire half_o
);
wire [2:0] v=open_i?3'h4:lvl_i;
assign {uv_o,ov_o,win_o,half_o}={v<3'h2,v>=3'h4,v==3'h2,v!=3'h0};
endmodule

// ===== tb/ovfs_sup_props.sv
`timescale 1ns/10ps
module ovfs_sup_props(
input wire clk_i,
input wire rst_n_i,
input wire ce_i,
input wire soft_start_done_i,
input wire low_side_mask_i,
input wire pwm_high_side_req_i,
input wire power_good_flag_o,
input wire high_side_gate_o,
input wire low_side_gate_o,
input wire undervoltage_trip_o,
input wire overvoltage_trip_o
);
// Short aliases of the outputs
wire u=undervoltage_trip_o,o=overvoltage_trip_o,h=high_side_gate_o;
wire l=low_side_gate_o,p=power_good_flag_o,f=u|o;
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
a_ov_hold: assert property (o|=>o&&!h) else $error("ov");
a_uv_hold: assert property (u|=>u) else $error("uv");
a_uv_off: assert property (u&&!o|->!h&&!l) else $error("uvg");
a_ov_rise: assert property ($rose(o)|->l&&!h) else $error("ovr");
a_pg_fault: assert property (f|->!p) else $error("pgf");
a_pg_ss: assert property ((ce_i&&!soft_start_done_i)[*6]|->!p) else $error("pgs");
a_pwm_hs: assert property (!f&&$past(ce_i&&rst_n_i)|->
h==$past(pwm_high_side_req_i)) else $error("pwm");
a_ls_mask: assert property (!f&&$past(ce_i&&rst_n_i&&low_side_mask_i)|->
!l) else $error("msk");
endmodule
bind ovfs_supervisor ovfs_sup_props ovfs_sup_props_inst(.*);

// ===== tb/tb_ovfs_supervisor.sv
`timescale 1ns/10ps
`define C(a,b) begin comparisons++; if((a)!==(b)) begin num_errors++; \
$display("[FAIL] %0t got %h exp %h",$time,a,b); end end
module tb_ovfs_supervisor;
logic clk_i=0,rst_n_i=0,ce_i=1,soft_start_done_i=0,low_side_mask_i=0;
logic pwm_high_side_req_i=0,pwm_low_side_req_i=0,op=0;
logic [2:0] lv=3'h2;
logic [1:0] b;
logic [5:0] e;
logic [5:0] q[$];
int num_errors=0,comparisons=0;
event ev;
wire output_sense_below_uv_i,output_sense_above_ov_i;
wire output_sense_in_window_i,output_sense_above_half_i;
wire power_good_flag_o,high_side_gate_o,low_side_gate_o;
wire undervoltage_trip_o,overvoltage_trip_o,sense_bias_en_o;
wire [5:0] got={sense_bias_en_o,power_good_flag_o,high_side_gate_o,
low_side_gate_o,
undervoltage_trip_o,overvoltage_trip_o};
always #50 clk_i=~clk_i;
ovfs_supervisor ovfs_supervisor_inst(.*);
ovfs_sense ovfs_sense_inst(.lvl_i(lv),.open_i(op),
.uv_o(output_sense_below_uv_i),.ov_o(output_sense_above_ov_i),
.win_o(output_sense_in_window_i),.half_o(output_sense_above_half_i));
task stop_test;
$display("errors %0d compares %0d",num_errors,comparisons);
if(num_errors==0&&comparisons>0) $display("No errors found");
else $display("Errors were found");
$finish;
endtask
// Level, soft-start, mask, pwm pair; then note expected outputs
task t(input [6:0] x,input [4:0] x_e);
{lv,soft_start_done_i,low_side_mask_i,pwm_high_side_req_i,
pwm_low_side_req_i}=x;
repeat(6) @(negedge clk_i);
q.push_back({1'b1,x_e});
->ev;
endtask
task rs;
rst_n_i=0;
repeat(12) @(negedge clk_i);
rst_n_i=1;
endtask
// Oldest note against outputs
always @ev
begin
   e=q.pop_front();
   `C(got,e)
end
// Watchdog
initial
begin
   #50000 num_errors++;
   stop_test;
end
initial
begin
   void'($urandom(32'hE0CACBCA));
   rs;
   t(7'h28,5'h10);
   repeat(8)
   begin
      b=2'($urandom);
      t({5'h0A,b},{1'b1,b,2'h0});
   end
   t(7'h3B,5'h0C);
   t(7'h00,5'h00);
   t(7'h0B,5'h02);
   t(7'h2B,5'h02);
   rs;
   t(7'h46,5'h05);
   t(7'h06,5'h01);
   t(7'h2F,5'h05);
   t(7'h0F,5'h03);
   t(7'h2F,5'h07);
   rs;
   op=1;
   t(7'h28,5'h05);
   op=0;
   rs;
   t(7'h2D,5'h10);
   // Clock enable low freezes every output
   ce_i=0;
   t(7'h33,5'h10);
   ce_i=1;
   t(7'h33,5'h0C);
   @(negedge clk_i);
   stop_test;
end
endmodule
